// ===== fpec_core.sv
// control register, unlock key and sequencer for flash program/erase
// assumes the register port master keeps the one-cycle strobe protocol
`timescale 1ns/1ps
// What this block does
// - setting start begins selected operation, timed internally, start clears at end
// - start reads zero whenever no operation is running
// - operations run only while enable bit is one
// - improper start attempt or termination sets sequence error flag
// - sequence error flag stays zero after a clean operation
// - erase select one makes next start run erase by op code
// - erase select zero makes next start run program by op code
// - erase with code 1101 erases general segment
// - erase with code 0010 erases one page
// - bits 12 to 7 and 5 to 4 ignore writes, read zero
// - program with code 0011 programs one word
module fpec_core #(
	parameter int PAGE_CYCLES = fpec_pkg::PAGE_ERASE_CYC,
	parameter int WORD_CYCLES = fpec_pkg::WORD_PROG_CYC,
	parameter int SEG_CYCLES = fpec_pkg::SEG_ERASE_CYC
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic flash_fault,
	output logic flash_busy,
	output logic [1:0] flash_op,
	output logic irq
);
	localparam int TW = 24;

	// ****************************************
	// bus capture
	// ****************************************
	fpec_pkg::fpec_bus_s bus;
	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// one write decoder for every register, so no two can disagree
	function automatic logic wr_hit(input fpec_pkg::fpec_bus_s b,
		input logic [3:0] a);
		return b.wr && b.addr == a;
	endfunction

	logic ctl_wr;
	logic key_wr;
	logic irq_clr_wr;
	logic irq_en_wr;
	assign ctl_wr = wr_hit(bus, fpec_pkg::ADDR_CONTROL);
	assign key_wr = wr_hit(bus, fpec_pkg::ADDR_KEY);
	assign irq_clr_wr = wr_hit(bus, fpec_pkg::ADDR_IRQ_CLEAR);
	assign irq_en_wr = wr_hit(bus, fpec_pkg::ADDR_IRQ_ENABLE);

	// ****************************************
	// control register fields
	// ****************************************
	logic start_reg;
	logic enable_reg;
	logic seq_err_reg;
	logic erase_sel_reg;
	logic [3:0] operation_code_reg;

	// ****************************************
	// unlock key tracking
	// ****************************************
	logic key_half_reg;
	logic unlocked_reg;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			key_half_reg <= 1'b0;
			unlocked_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			// any other access in between breaks the sequence
			if (key_wr)
			begin
				key_half_reg <= bus.wdata[7:0] == fpec_pkg::KEY_FIRST;
				unlocked_reg <= key_half_reg &&
					bus.wdata[7:0] == fpec_pkg::KEY_SECOND;
			end
			else if (bus.wr || bus.rd)
			begin
				// the unlock is spent by the very next access, used or not
				key_half_reg <= 1'b0;
				unlocked_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// operation decode
	// ****************************************
	function automatic fpec_pkg::fpec_op_e decode_op(input logic erase,
		input logic [3:0] code);
		fpec_pkg::fpec_op_e op;
		op = fpec_pkg::FPEC_OP_NONE;
		if (erase)
		begin
			if (code == fpec_pkg::OP_GEN_SEGMENT)
				op = fpec_pkg::FPEC_OP_SEG;
			else if (code == fpec_pkg::OP_PAGE)
				op = fpec_pkg::FPEC_OP_PAGE;
		end
		else if (code == fpec_pkg::OP_WORD)
		begin
			op = fpec_pkg::FPEC_OP_WORD;
		end
		return op;
	endfunction

	// unlisted codes still take one cycle so start reads back and clears
	function automatic logic [TW-1:0] op_cycles(input fpec_pkg::fpec_op_e op);
		logic [TW-1:0] c;
		c = TW'(1);
		case (op)
			fpec_pkg::FPEC_OP_WORD: c = TW'(WORD_CYCLES);
			fpec_pkg::FPEC_OP_PAGE: c = TW'(PAGE_CYCLES);
			fpec_pkg::FPEC_OP_SEG: c = TW'(SEG_CYCLES);
			default: c = TW'(1);
		endcase
		return c;
	endfunction

	// the new fields of this write select the operation
	fpec_pkg::fpec_op_e new_op;
	assign new_op = decode_op(bus.wdata[fpec_pkg::BIT_ERASE_SEL],
		bus.wdata[3:0]);

	logic start_try;
	logic start_ok;
	assign start_try = ctl_wr && bus.wdata[fpec_pkg::BIT_START] && !start_reg;
	assign start_ok = start_try && enable_reg && bus.wdata[fpec_pkg::BIT_ENABLE]
		&& unlocked_reg;

	// ****************************************
	// sequencer state
	// ****************************************
	typedef enum logic [1:0] {
		FPEC_IDLE = 2'b00,
		FPEC_RUN = 2'b01
	} fpec_state_e;
	fpec_state_e state_reg;

	logic tmr_busy;
	logic tmr_done;
	logic abort;
	logic fault_meta_reg;
	logic fault_sync_reg;
	// dropping enable mid-operation is an improper termination
	assign abort = state_reg == FPEC_IDLE ? 1'b0 :
		(fault_sync_reg || (ctl_wr && !bus.wdata[fpec_pkg::BIT_ENABLE]));

	// one shared timer: operations never overlap, so one counter suffices
	fpec_timer #(
		.WIDTH(TW)
	) u_timer (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.load(start_ok),
		.cycles(op_cycles(new_op)),
		.abort(abort),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// fault pin comes from the flash macro, another timing domain
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			fault_meta_reg <= 1'b0;
			fault_sync_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			fault_meta_reg <= flash_fault;
			fault_sync_reg <= fault_meta_reg;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= FPEC_IDLE;
			flash_op <= 2'b00;
			flash_busy <= 1'b0;
		end
		else if (clk_en)
		begin
			case (state_reg)
				FPEC_IDLE:
				begin
					if (start_ok)
					begin
						state_reg <= FPEC_RUN;
						flash_op <= new_op;
						flash_busy <= 1'b1;
					end
				end
				FPEC_RUN:
				begin
					// the idle-timer fallback guards against a lost done pulse
					if (abort || tmr_done || (!tmr_busy && !start_ok))
					begin
						state_reg <= FPEC_IDLE;
						flash_op <= 2'b00;
						flash_busy <= 1'b0;
					end
				end
				default:
				begin
					state_reg <= FPEC_IDLE;
					flash_op <= 2'b00;
					flash_busy <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// control register update
	// ****************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			start_reg <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_START];
			enable_reg <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_ENABLE];
			erase_sel_reg <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_ERASE_SEL];
			operation_code_reg <= fpec_pkg::CONTROL_RESET[3:0];
		end
		else if (clk_en)
		begin
			if (ctl_wr)
			begin
				enable_reg <= bus.wdata[fpec_pkg::BIT_ENABLE];
				// erase select and op code are frozen while an operation runs
				if (!start_reg)
				begin
					erase_sel_reg <= bus.wdata[fpec_pkg::BIT_ERASE_SEL];
					operation_code_reg <= bus.wdata[3:0];
				end
			end
			// start clears only on done or abort, never by software
			if (start_ok)
				start_reg <= 1'b1;
			else if (abort || tmr_done)
				start_reg <= 1'b0;
		end
	end

	// error flag: hardware set wins over software clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			seq_err_reg <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_SEQ_ERR];
		else if (clk_en)
		begin
			if ((start_try && !start_ok) || abort)
				seq_err_reg <= 1'b1;
			else if (start_ok)
				seq_err_reg <= 1'b0;
			else if (ctl_wr && !bus.wdata[fpec_pkg::BIT_SEQ_ERR])
				seq_err_reg <= 1'b0;
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	logic [1:0] irq_status_reg;
	logic [1:0] irq_enable_reg;
	logic [1:0] irq_event;
	logic [1:0] irq_clear;
	logic [1:0] irq_status_next;
	logic [1:0] irq_enable_next;
	assign irq_event = {(start_try && !start_ok) || abort, tmr_done};
	assign irq_clear = irq_clr_wr ? bus.wdata[1:0] : 2'b00;
	// an event in the cycle of its own clear stays set
	assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;
	assign irq_enable_next = irq_en_wr ? bus.wdata[1:0] : irq_enable_reg;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			irq_status_reg <= fpec_pkg::IRQ_RESET;
			irq_enable_reg <= fpec_pkg::IRQ_RESET;
			irq <= 1'b0;
		end
		else if (clk_en)
		begin
			irq_status_reg <= irq_status_next;
			irq_enable_reg <= irq_enable_next;
			// built from next values so the pin tracks the status register
			irq <= |(irq_status_next & irq_enable_next);
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= 16'h0000;
		else if (clk_en)
		begin
			reg_rdata <= 16'h0000;
			if (bus.rd)
			begin
				case (bus.addr)
					fpec_pkg::ADDR_CONTROL:
						reg_rdata <= {start_reg, enable_reg, seq_err_reg, 6'h00,
							erase_sel_reg, 2'h0, operation_code_reg};
					fpec_pkg::ADDR_IRQ_STATUS:
						reg_rdata <= {14'h0000, irq_status_reg};
					fpec_pkg::ADDR_IRQ_ENABLE:
						reg_rdata <= {14'h0000, irq_enable_reg};
					// key and clear are write-only and read as zero
					fpec_pkg::ADDR_KEY,
					fpec_pkg::ADDR_IRQ_CLEAR:
						reg_rdata <= 16'h0000;
					// unmapped reads return zero
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// ===== fpec_pkg.sv
// package for the flash program/erase control block
// assumes a 16-bit register port and a 100 MHz system clock
package fpec_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_KEY = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
	// ****************************************
	// control fields
	// ****************************************
	localparam int BIT_START = 15;
	localparam int BIT_ENABLE = 14;
	localparam int BIT_SEQ_ERR = 13;
	localparam int BIT_ERASE_SEL = 6;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [3:0] OP_GEN_SEGMENT = 4'hD;
	localparam logic [3:0] OP_PAGE = 4'h2;
	localparam logic [3:0] OP_WORD = 4'h3;
	// irq bits: 0 done, 1 sequence error
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 100;
	localparam int PAGE_ERASE_US = 20000;
	localparam int WORD_PROG_US = 40;
	localparam int SEG_ERASE_US = 20000;
	localparam int PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
	localparam int WORD_PROG_CYC = WORD_PROG_US * CLK_MHZ;
	localparam int SEG_ERASE_CYC = SEG_ERASE_US * CLK_MHZ;

	typedef enum logic [1:0] {
		FPEC_OP_NONE = 2'b00,
		FPEC_OP_WORD = 2'b01,
		FPEC_OP_PAGE = 2'b10,
		FPEC_OP_SEG = 2'b11
	} fpec_op_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} fpec_bus_s;
endpackage

// ===== fpec_timer.sv
// self-timed down counter for one flash operation
// assumes load is a single-cycle pulse from the same clock
`timescale 1ns/1ps
module fpec_timer #(
	parameter int WIDTH = 24
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [WIDTH-1:0] cycles,
	input wire logic abort,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] count_reg;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else if (clk_en)
		begin
			done <= 1'b0;
			if (load)
			begin
				count_reg <= cycles;
				busy <= 1'b1;
			end
			else if (busy && abort)
			begin
				busy <= 1'b0;
			end
			else if (busy)
			begin
				if (count_reg <= 1)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// ===== fpec_core_chk.sv
// checker for the flash program/erase control core
// assumes one-cycle bus strobes and no strobe while clk_en is low
`timescale 1ns/1ps
module fpec_chk #(
	parameter int PAGE_CYCLES = 20,
	parameter int WORD_CYCLES = 8,
	parameter int SEG_CYCLES = 30
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic flash_fault,
	input wire logic flash_busy,
	input wire logic [1:0] flash_op,
	input wire logic irq
);
	// ****
	// helpers
	// ****
	logic [15:0] ctl_last;
	int busy_cnt;
	fpec_pkg::fpec_op_e op_exp;
	always_ff @(posedge clk or posedge reset)
		if (reset)
			ctl_last <= 16'h0000;
		else if (reg_wr && reg_addr == fpec_pkg::ADDR_CONTROL)
			ctl_last <= reg_wdata;
	// a loose bound: aborts end runs early, so no exact length here
	always_ff @(posedge clk or posedge reset)
		if (reset)
			busy_cnt <= 0;
		else
			busy_cnt <= flash_busy ? busy_cnt + 1 : 0;
	always_comb
		case ({ctl_last[6], ctl_last[3:0]})
			5'h1D: op_exp = fpec_pkg::FPEC_OP_SEG;
			5'h12: op_exp = fpec_pkg::FPEC_OP_PAGE;
			5'h03: op_exp = fpec_pkg::FPEC_OP_WORD;
			default: op_exp = fpec_pkg::FPEC_OP_NONE;
		endcase
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero");
	unimpl_zero_a: assert property ($past(reg_rd) &&
		$past(reg_addr) == fpec_pkg::ADDR_CONTROL |->
		reg_rdata[12:7] == 6'h00 && reg_rdata[5:4] == 2'h0)
		else $error("unused bits not zero");
	start_cause_a: assert property ($rose(flash_busy) |->
		$past(reg_wr) && $past(reg_wdata[15:14]) == 2'h3)
		else $error("busy without start write");
	unlock_order_a: assert property ($rose(flash_busy) |->
		$past(reg_wdata[7:0], 2) == fpec_pkg::KEY_SECOND &&
		$past(reg_wdata[7:0], 3) == fpec_pkg::KEY_FIRST)
		else $error("start without unlock");
	op_select_a: assert property ($rose(flash_busy) |->
		flash_op == op_exp)
		else $error("wrong operation");
	abort_enable_a: assert property (flash_busy && reg_wr &&
		reg_addr == fpec_pkg::ADDR_CONTROL && !reg_wdata[14] |->
		##[1:3] !flash_busy)
		else $error("enable drop did not abort");
	fault_abort_a: assert property (flash_busy && flash_fault |->
		##[1:5] !flash_busy)
		else $error("fault did not abort");
	busy_bound_a: assert property (flash_busy |->
		busy_cnt < PAGE_CYCLES + SEG_CYCLES + WORD_CYCLES)
		else $error("operation never ends");
	freeze_hold_a: assert property (!clk_en |=> $stable(flash_busy) &&
		$stable(flash_op) && $stable(reg_rdata) && $stable(irq))
		else $error("state moved while frozen");
	cover property (flash_busy && !clk_en);
	cover property ($rose(flash_busy) && flash_op == fpec_pkg::FPEC_OP_SEG);
	cover property ($rose(flash_busy) && flash_op == fpec_pkg::FPEC_OP_PAGE);
	cover property ($rose(flash_busy) && flash_op == fpec_pkg::FPEC_OP_WORD);
endmodule
bind fpec_core fpec_chk #(
	.PAGE_CYCLES(PAGE_CYCLES),
	.WORD_CYCLES(WORD_CYCLES),
	.SEG_CYCLES(SEG_CYCLES)
) chk (
	.clk(clk),
	.reset(reset),
	.clk_en(clk_en),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.flash_fault(flash_fault),
	.flash_busy(flash_busy),
	.flash_op(flash_op),
	.irq(irq)
);

// ===== fpec_core_tb_top.sv
// self-checking bench for the flash program/erase control core
// assumes the checker is bound beside the core
`timescale 1ns/1ps
module fpec_core_tb_top;
	typedef struct packed {
		logic [15:0] ctl;
		fpec_pkg::fpec_op_e op;
	} fpec_row_s;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic flash_fault = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] reg_rdata;
	logic flash_busy;
	logic [1:0] flash_op;
	logic irq;
	logic [15:0] v;
	int errors = 0;
	int checks = 0;
	fpec_row_s rows [9] = '{
		'{16'h004D, fpec_pkg::FPEC_OP_SEG},
		'{16'h0042, fpec_pkg::FPEC_OP_PAGE},
		'{16'h0003, fpec_pkg::FPEC_OP_WORD},
		'{16'h004F, fpec_pkg::FPEC_OP_NONE},
		'{16'h004C, fpec_pkg::FPEC_OP_NONE},
		'{16'h0040, fpec_pkg::FPEC_OP_NONE},
		'{16'h0043, fpec_pkg::FPEC_OP_NONE},
		'{16'h000D, fpec_pkg::FPEC_OP_NONE},
		'{16'h0002, fpec_pkg::FPEC_OP_NONE}
	};
	fpec_core #(
		.PAGE_CYCLES(20),
		.WORD_CYCLES(8),
		.SEG_CYCLES(30)
	) DUT (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.flash_fault(flash_fault),
		.flash_busy(flash_busy),
		.flash_op(flash_op),
		.irq(irq)
	);
	initial
		forever
			#5 clk = ~clk;
	task automatic chk(input logic [15:0] s, input logic [15:0] e, string m);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask
	task automatic settle();
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic keys();
		wr(fpec_pkg::ADDR_KEY, {8'h00, fpec_pkg::KEY_FIRST});
		wr(fpec_pkg::ADDR_KEY, {8'h00, fpec_pkg::KEY_SECOND});
	endtask
	task automatic go(input logic [15:0] c);
		wr(fpec_pkg::ADDR_CONTROL, 16'h4000 | c);
		keys();
		wr(fpec_pkg::ADDR_CONTROL, 16'hC000 | c);
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// polls the start bit the way software would
	task automatic wait_done();
		int n = 0;
		v = 16'h8000;
		while (v[15] !== 1'b0 && n < 40)
		begin
			rd(fpec_pkg::ADDR_CONTROL);
			n++;
		end
		if (v[15] !== 1'b0)
		begin
			chk({15'h0000, v[15]}, 16'h0000, "start stuck");
			summarize();
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(fpec_pkg::ADDR_CONTROL);
		chk(v, 16'h0000, "control reset");
		chk({15'h0000, irq}, 16'h0000, "irq reset");
		$display("test reset done");
		foreach (rows[i])
		begin
			go(rows[i].ctl);
			chk({14'h0, flash_op}, {14'h0, rows[i].op}, "op");
			chk({15'h0000, flash_busy}, 16'h0001, "busy on start");
			wait_done();
			chk(v, 16'h4000 | rows[i].ctl, "ctl after op");
			chk({15'h0000, flash_busy}, 16'h0000, "busy");
		end
		$display("test table done");
		wr(fpec_pkg::ADDR_CONTROL, 16'h5FB3);
		rd(fpec_pkg::ADDR_CONTROL);
		chk(v, 16'h4003, "unused bits");
		rd(4'h9);
		chk(v, 16'h0000, "unmapped read");
		wr(fpec_pkg::ADDR_IRQ_CLEAR, 16'h0003);
		wr(fpec_pkg::ADDR_IRQ_ENABLE, 16'h0003);
		wr(fpec_pkg::ADDR_KEY, 16'h00AA);
		wr(fpec_pkg::ADDR_KEY, 16'h0055);
		wr(fpec_pkg::ADDR_CONTROL, 16'hC003);
		settle();
		chk({15'h0000, flash_busy}, 16'h0000, "bad key");
		chk({15'h0000, irq}, 16'h0001, "irq raised");
		rd(fpec_pkg::ADDR_CONTROL);
		chk(v, 16'h6003, "bad key flags");
		wr(fpec_pkg::ADDR_IRQ_ENABLE, 16'h0001);
		settle();
		chk({15'h0000, irq}, 16'h0000, "irq masked");
		wr(fpec_pkg::ADDR_IRQ_CLEAR, 16'h0002);
		wr(fpec_pkg::ADDR_IRQ_ENABLE, 16'h0003);
		settle();
		chk({15'h0000, irq}, 16'h0000, "irq cleared");
		wr(fpec_pkg::ADDR_CONTROL, 16'h4003);
		keys();
		rd(fpec_pkg::ADDR_KEY);
		chk(v, 16'h0000, "key reads zero");
		wr(fpec_pkg::ADDR_CONTROL, 16'hC003);
		settle();
		chk({15'h0000, flash_busy}, 16'h0000, "read between");
		$display("test refusal done");
		wr(fpec_pkg::ADDR_CONTROL, 16'h4003);
		keys();
		wr(fpec_pkg::ADDR_CONTROL, 16'h8003);
		settle();
		chk({15'h0000, flash_busy}, 16'h0000, "no enable");
		rd(fpec_pkg::ADDR_CONTROL);
		chk(v, 16'h2003, "no enable flags");
		go(16'h0042);
		wr(fpec_pkg::ADDR_CONTROL, 16'h0042);
		settle();
		chk({15'h0000, flash_busy}, 16'h0000, "abort");
		rd(fpec_pkg::ADDR_CONTROL);
		chk(v, 16'h2042, "abort flags");
		go(16'h0003);
		@(posedge clk);
		flash_fault <= 1'b1;
		repeat (3) @(posedge clk);
		flash_fault <= 1'b0;
		settle();
		rd(fpec_pkg::ADDR_CONTROL);
		chk(v, 16'h6003, "fault flags");
		$display("test abort done");
		wr(fpec_pkg::ADDR_IRQ_CLEAR, 16'h0003);
		go(16'h0003);
		// freeze mid-operation: the timer must not advance
		@(posedge clk);
		clk_en <= 1'b0;
		repeat (20) @(posedge clk);
		clk_en <= 1'b1;
		#1;
		chk({15'h0000, flash_busy}, 16'h0001, "frozen busy");
		wait_done();
		chk(v, 16'h4003, "clean op");
		rd(fpec_pkg::ADDR_IRQ_STATUS);
		chk(v, 16'h0001, "done status");
		chk({15'h0000, irq}, 16'h0001, "done irq");
		$display("test clean done");
		summarize();
	end
endmodule
